// ---- rtl/rwc_pkg.sv ----
/*
  Package for the reset and watchdog controller: register offsets, field
  positions, reset values, timing counts and carrier types.
  Assumes a single 125 MHz system clock and a plain strobe register port.
*/
package rwc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the plain port)
  localparam logic [7:0] RWC_ADDR_STATUS = 8'h00;  // Reset cause flags
  localparam logic [7:0] RWC_ADDR_WDCTL  = 8'h04;  // Watchdog control
  localparam logic [7:0] RWC_ADDR_MISC   = 8'h08;  // Reference requests and state

  // ==========================================================================
  // Reset cause flag positions
  localparam int RWC_FLG_POWERON  = 0;
  localparam int RWC_FLG_EXTERNAL = 1;
  localparam int RWC_FLG_BROWNOUT = 2;
  localparam int RWC_FLG_WATCHDOG = 3;

  // Watchdog control field positions
  localparam int RWC_WD_PRE0 = 0;
  localparam int RWC_WD_PRE1 = 1;
  localparam int RWC_WD_PRE2 = 2;
  localparam int RWC_WD_RST  = 3;
  localparam int RWC_WD_CHG  = 4;
  localparam int RWC_WD_PRE3 = 5;
  localparam int RWC_WD_IEN  = 6;
  localparam int RWC_WD_IFL  = 7;

  // Misc register field positions
  localparam int RWC_MS_COMPARATOR_BANDGAP_SELECT  = 0;
  localparam int RWC_MS_ADCEN = 1;
  localparam int RWC_MS_REFON = 2;
  localparam int RWC_MS_HELD  = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RWC_WDCTL_RST = 8'h00;
  localparam logic [7:0] RWC_MISC_RST  = 8'h00;

  // ==========================================================================
  // Timing
  localparam int          RWC_CLK_MHZ       = 125;
  localparam int          RWC_WDOSC_KHZ     = 128;
  // Watchdog oscillator tick period in system clocks, shortest-time rounding
  localparam int          RWC_WDOSC_DIV     = (RWC_CLK_MHZ * 1000) / RWC_WDOSC_KHZ;
  localparam logic [9:0]  RWC_WDOSC_DIV_M1  = 10'(RWC_WDOSC_DIV - 1);
  localparam int          RWC_CHG_WIN       = 4;     // Change window, clocks
  localparam logic [2:0]  RWC_CHG_WIN_W     = 3'(RWC_CHG_WIN);
  localparam logic [16:0] RWC_WD_BASE       = 17'h00800;  // 2048 cycles at code 0
  localparam logic [3:0]  RWC_WD_MAXCODE    = 4'h6;
  localparam int          RWC_STRETCH_W     = 24;
  localparam int          RWC_BROWN_MIN_NS  = 2000;  // Least dip duration
  localparam int          RWC_BROWN_MIN_CYC = (RWC_BROWN_MIN_NS * RWC_CLK_MHZ + 999) / 1000;
  localparam logic [8:0]  RWC_BROWN_MIN_W   = 9'(RWC_BROWN_MIN_CYC);
  localparam int          RWC_EXT_MIN_NS    = 2500;  // Least reset pin pulse
  localparam int          RWC_EXT_MIN_CYC   = (RWC_EXT_MIN_NS * RWC_CLK_MHZ + 999) / 1000;
  localparam logic [8:0]  RWC_EXT_MIN_W     = 9'(RWC_EXT_MIN_CYC);

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rwc_bus_s;

  typedef struct packed {
    logic       poweron_low;    // Supply below power-on level
    logic       brownout_low;   // Supply below brown-out level
    logic       reset_pin_n;    // External reset pin level
  } rwc_analog_s;

  typedef enum logic [2:0] {
    RWC_ST_HOLD  = 3'b001,
    RWC_ST_COUNT = 3'b010,
    RWC_ST_RUN   = 3'b100
  } rwc_state_e;

endpackage

// ---- rtl/rwc_reset_watchdog_control.sv ----
/*
  Reset merge, start-up stretch, reference enable and watchdog timer.
  Assumes analog detector outputs and the reset pin are asynchronous to
  sys_clk, that fuses are static, and that the core pulses watchdog_restart
  for its restart instruction and irq_ack when it enters the watchdog vector.
*/
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns

module rwc_reset_watchdog_control
  import rwc_pkg::*;
#(
  parameter int STARTUP_CYCLES = 8192  // Start-up delay count from fuses
) (
  // Clock and test reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Analog detectors and reset pin
  input  wire rwc_analog_s              analog,
  // Fuses
  input  wire logic                     brownout_detector_fuse,
  input  wire logic                     watchdog_always_on_fuse_n,
  input  wire logic                     reset_pin_enable_fuse,
  input  wire logic [1:0]               startup_time_fuse,
  input  wire logic [3:0]               clock_source_fuse,
  // Core
  input  wire logic                     watchdog_restart,
  input  wire logic                     irq_ack,
  // Register port
  input  wire rwc_bus_s                 bus,
  output logic [7:0]                    rdata,
  // Results
  output logic                          port_reset,
  output logic                          core_reset,
  output logic                          watchdog_irq,
  output logic                          reference_enable
);

  // ==========================================================================
  // Input synchronisers (two flops, first flop read only by the second)
  // They reset to the asserted level, so the block starts as if every
  // source were active and never runs on stale pin levels
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
    end else begin
      sync1_r <= {analog.poweron_low, analog.brownout_low, ~analog.reset_pin_n};
      sync2_r <= sync1_r;
    end
  end

  logic por_s, bo_s, pin_s;
  assign por_s = sync2_r[2];
  assign bo_s  = sync2_r[1] & brownout_detector_fuse;
  assign pin_s = sync2_r[0] & reset_pin_enable_fuse;

  // ==========================================================================
  // Glitch filters: a level must stand the minimum time to count
  // Limitation: the filter is only as fine as the clock, so a dip right at
  // the limit may or may not count; both outcomes are allowed
  logic [8:0] bo_cnt_r, pin_cnt_r;
  logic       bo_hit_r, pin_hit_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bo_cnt_r <= 9'h000;
      bo_hit_r <= 1'b0;
    end else if (!bo_s) begin
      bo_cnt_r <= 9'h000;
      bo_hit_r <= 1'b0;
    end else if (bo_cnt_r >= RWC_BROWN_MIN_W) begin
      bo_hit_r <= 1'b1;
    end else begin
      bo_cnt_r <= bo_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_cnt_r <= 9'h000;
      pin_hit_r <= 1'b0;
    end else if (!pin_s) begin
      pin_cnt_r <= 9'h000;
      pin_hit_r <= 1'b0;
    end else if (pin_cnt_r >= RWC_EXT_MIN_W) begin
      pin_hit_r <= 1'b1;
    end else begin
      pin_cnt_r <= pin_cnt_r + 9'h001;
    end
  end

  // ==========================================================================
  // Source merge; power-on and pin also act without a clock
  // The watchdog pulse joins only after its own register, one clock long
  logic wd_pulse_r;
  logic any_src;
  assign any_src = por_s | bo_hit_r | pin_hit_r | wd_pulse_r;

  // Asynchronous port reset: power-on and pin levels act directly, no clock needed
  always_comb begin
    port_reset = rst | analog.poweron_low | any_src
               | (reset_pin_enable_fuse & ~analog.reset_pin_n)
               | core_reset;
  end

  // ==========================================================================
  // Start-up stretch: counter restarts while any source stands
  // A source that returns mid-count sends the machine back to hold, so the
  // full delay always follows the last source to go inactive
  logic [RWC_STRETCH_W-1:0] stretch_r;
  rwc_state_e               st_r;

  // Fuse selection lengthens the delay; slow sources get extra padding
  logic [RWC_STRETCH_W-1:0] stretch_len;
  assign stretch_len = RWC_STRETCH_W'(STARTUP_CYCLES)
                     << {startup_time_fuse, (clock_source_fuse == 4'h0)};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r      <= RWC_ST_HOLD;
      stretch_r <= '0;
    end else begin
      case (st_r)
        RWC_ST_HOLD: begin
          stretch_r <= '0;
          if (!any_src) st_r <= RWC_ST_COUNT;
        end
        RWC_ST_COUNT: begin
          if (any_src) begin
            st_r <= RWC_ST_HOLD;
          end else if (stretch_r >= stretch_len) begin
            st_r <= RWC_ST_RUN;
          end else begin
            stretch_r <= stretch_r + 1'b1;
          end
        end
        RWC_ST_RUN: begin
          if (any_src) st_r <= RWC_ST_HOLD;
        end
        default: st_r <= RWC_ST_HOLD;
      endcase
    end
  end

  // Core reset leaves on a clock edge only once the count is done. Power-on
  // clears the release flop without a clock so the core stops at once; the
  // release itself stays on the clock, so no core flop sees a runt edge.
  logic release_r;
  logic por_async;
  assign por_async = rst | analog.poweron_low;

  always_ff @(posedge sys_clk or posedge por_async) begin
    if (por_async) begin
      release_r <= 1'b0;
    end else begin
      release_r <= (st_r == RWC_ST_RUN) & ~any_src;
    end
  end
  assign core_reset = ~release_r;

  // ==========================================================================
  // Reset cause flags
  // Writes are ignored during core reset, like every other register write
  logic [3:0] flags_r;
  logic       wr_stat;
  assign wr_stat = bus.wr & ~core_reset & (bus.addr == RWC_ADDR_STATUS);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_r <= 4'h0;
    end else if (por_s) begin
      flags_r <= 4'h1;
    end else begin
      // Set wins over a same-cycle write of zero
      flags_r[RWC_FLG_POWERON]  <= wr_stat ? bus.wdata[RWC_FLG_POWERON]
                                            & flags_r[RWC_FLG_POWERON]
                                          : flags_r[RWC_FLG_POWERON];
      flags_r[RWC_FLG_EXTERNAL] <= pin_hit_r | (flags_r[RWC_FLG_EXTERNAL]
                                   & ~(wr_stat & ~bus.wdata[RWC_FLG_EXTERNAL]));
      flags_r[RWC_FLG_BROWNOUT] <= bo_hit_r | (flags_r[RWC_FLG_BROWNOUT]
                                   & ~(wr_stat & ~bus.wdata[RWC_FLG_BROWNOUT]));
      flags_r[RWC_FLG_WATCHDOG] <= wd_pulse_r | (flags_r[RWC_FLG_WATCHDOG]
                                   & ~(wr_stat & ~bus.wdata[RWC_FLG_WATCHDOG]));
    end
  end

  // ==========================================================================
  // Watchdog control register with timed change sequence
  logic       wd_rst_en_r, wd_irq_en_r, wd_flag_r, wd_chg_r;
  logic [3:0] wd_pre_r;
  logic [2:0] chg_cnt_r;
  logic       wr_wd, fuse_on, wd_expire, eff_ren, eff_ien;
  logic [3:0] wr_pre;
  assign wr_wd   = bus.wr & (bus.addr == RWC_ADDR_WDCTL);
  assign fuse_on = ~watchdog_always_on_fuse_n;
  assign wr_pre  = {bus.wdata[RWC_WD_PRE3], bus.wdata[RWC_WD_PRE2],
                    bus.wdata[RWC_WD_PRE1], bus.wdata[RWC_WD_PRE0]};

  // Change window: opens on enable+reset write, closes after four clocks
  // An opening write inside a live window restarts the count; opening wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_chg_r  <= 1'b0;
      chg_cnt_r <= 3'h0;
    end else if (core_reset) begin
      wd_chg_r  <= 1'b0;
      chg_cnt_r <= 3'h0;
    end else if (wr_wd & bus.wdata[RWC_WD_CHG] & bus.wdata[RWC_WD_RST]) begin
      wd_chg_r  <= 1'b1;
      chg_cnt_r <= 3'h0;
    end else if (wr_wd & wd_chg_r) begin
      wd_chg_r  <= 1'b0;  // Closing write consumes the window
    end else if (wd_chg_r) begin
      chg_cnt_r <= chg_cnt_r + 3'h1;
      if (chg_cnt_r == RWC_CHG_WIN_W - 3'h1) wd_chg_r <= 1'b0;
    end
  end

  // Protected fields: reset enable may only be cleared and prescaler changed
  // by a write with the change bit low while the window is open
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_rst_en_r <= RWC_WDCTL_RST[RWC_WD_RST];
      wd_pre_r    <= 4'h0;
    end else if (core_reset) begin
      wd_rst_en_r <= RWC_WDCTL_RST[RWC_WD_RST];
      wd_pre_r    <= 4'h0;
    end else if (wr_wd) begin
      if (wd_chg_r & ~bus.wdata[RWC_WD_CHG]) begin
        wd_rst_en_r <= bus.wdata[RWC_WD_RST];
        wd_pre_r    <= wr_pre;
      end else if (bus.wdata[RWC_WD_RST]) begin
        wd_rst_en_r <= 1'b1;  // Setting needs no sequence
      end
    end
  end

  // Interrupt enable and flag; combined mode drops the enable on service
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_irq_en_r <= 1'b0;
      wd_flag_r   <= 1'b0;
    end else if (core_reset) begin
      wd_irq_en_r <= 1'b0;
      wd_flag_r   <= 1'b0;
    end else begin
      if (wd_expire & eff_ien) begin
        wd_flag_r <= 1'b1;
      end else if (irq_ack | (wr_wd & bus.wdata[RWC_WD_IFL])) begin
        wd_flag_r <= 1'b0;
      end
      if (irq_ack & eff_ren) begin
        wd_irq_en_r <= 1'b0;
      end else if (wr_wd) begin
        wd_irq_en_r <= bus.wdata[RWC_WD_IEN];
      end
    end
  end

  // Effective mode after fuse and flag overrides; the flag seen here keeps
  // the watchdog armed across the reset that it caused
  assign eff_ren = wd_rst_en_r | flags_r[RWC_FLG_WATCHDOG] | fuse_on;
  assign eff_ien = wd_irq_en_r & ~fuse_on;

  // ==========================================================================
  // Watchdog oscillator tick and counter
  // The divider rounds the tick period down, so a time-out runs slightly
  // short, by under one system clock per oscillator tick
  logic [9:0]  tick_cnt_r;
  logic        tick;
  logic [16:0] wd_cnt_r;
  logic [16:0] wd_limit;
  logic        wd_run;
  assign tick     = (tick_cnt_r == RWC_WDOSC_DIV_M1);
  assign wd_limit = RWC_WD_BASE << ((wd_pre_r > RWC_WD_MAXCODE) ? RWC_WD_MAXCODE
                                                                 : wd_pre_r);
  assign wd_run   = eff_ren | eff_ien;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) tick_cnt_r <= 10'h000;
    else     tick_cnt_r <= tick ? 10'h000 : tick_cnt_r + 10'h001;
  end

  assign wd_expire = tick & wd_run & (wd_cnt_r >= wd_limit - 17'h00001);

  // Held clear while stopped or in core reset, so each run starts from a
  // full period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_cnt_r <= 17'h00000;
    end else if (watchdog_restart | ~wd_run | core_reset) begin
      wd_cnt_r <= 17'h00000;
    end else if (tick) begin
      wd_cnt_r <= wd_expire ? 17'h00000 : wd_cnt_r + 17'h00001;
    end
  end

  // Reset on expiry when reset mode is active and the interrupt is not enabled;
  // in combined mode the first expiry only sets the flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) wd_pulse_r <= 1'b0;
    else     wd_pulse_r <= wd_expire & eff_ren & ~eff_ien & ~core_reset;
  end

  assign watchdog_irq = wd_flag_r & eff_ien;

  // ==========================================================================
  // Reference requests
  // Only the request is kept here; waiting out the start-up is software's part
  logic comparator_bandgap_select_r, adcen_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comparator_bandgap_select_r  <= RWC_MISC_RST[RWC_MS_COMPARATOR_BANDGAP_SELECT];
      adcen_r <= RWC_MISC_RST[RWC_MS_ADCEN];
    end else if (core_reset) begin
      comparator_bandgap_select_r  <= RWC_MISC_RST[RWC_MS_COMPARATOR_BANDGAP_SELECT];
      adcen_r <= RWC_MISC_RST[RWC_MS_ADCEN];
    end else if (bus.wr & (bus.addr == RWC_ADDR_MISC)) begin
      comparator_bandgap_select_r  <= bus.wdata[RWC_MS_COMPARATOR_BANDGAP_SELECT];
      adcen_r <= bus.wdata[RWC_MS_ADCEN];
    end
  end
  assign reference_enable = brownout_detector_fuse | comparator_bandgap_select_r | adcen_r;

  // ==========================================================================
  // Read data, one cycle after the strobe; unmapped reads return zero
  // Reads have no side effects; flags clear only by writes, vector entry, power-on or core reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        RWC_ADDR_STATUS: rdata <= {4'h0, flags_r};
        RWC_ADDR_WDCTL:  rdata <= {wd_flag_r, eff_ien, wd_pre_r[3], wd_chg_r,
                                   eff_ren, wd_pre_r[2:0]};
        RWC_ADDR_MISC:   rdata <= {4'h0, core_reset, reference_enable, adcen_r, comparator_bandgap_select_r};
        default:         rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // rwc_reset_watchdog_control

// ---- test/rwc_reset_watchdog_control_props.sv ----
/*
  Checker for the reset and watchdog controller, bound to its top module.
  Assumes fuses only change while rst is high.
*/
`timescale 1ns/1ns
module rwc_reset_watchdog_control_props
  import rwc_pkg::*;
#(
  parameter int STARTUP_CYCLES = 8192
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Watched inputs
  input wire rwc_analog_s analog,
  input wire logic        brownout_detector_fuse,
  input wire logic        watchdog_always_on_fuse_n,
  input wire logic        reset_pin_enable_fuse,
  input wire logic [1:0]  startup_time_fuse,
  input wire logic [3:0]  clock_source_fuse,
  input wire logic        watchdog_restart,
  input wire logic        irq_ack,
  input wire rwc_bus_s    bus,
  // Watched outputs
  input wire logic [7:0]  rdata,
  input wire logic        port_reset,
  input wire logic        core_reset,
  input wire logic        watchdog_irq,
  input wire logic        reference_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Helper counters
  logic [15:0] quiet_r;
  logic [9:0]  pin_r;
  logic [9:0]  bo_r;
  logic        pin_on;
  logic        bo_on;
  assign pin_on = reset_pin_enable_fuse & ~analog.reset_pin_n;
  assign bo_on  = brownout_detector_fuse & analog.brownout_low;

  // Quiet time since any power-on, pin or brown-out level; saturates so a long run never wraps to 0
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) quiet_r <= '0;
    else if (analog.poweron_low | pin_on | bo_on) quiet_r <= '0;
    else if (quiet_r != 16'hffff) quiet_r <= quiet_r + 16'h0001;
  end

  // Length of the present pin pulse and brown-out dip
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) pin_r <= '0;
    else if (!pin_on) pin_r <= '0;
    else if (pin_r != 10'h3ff) pin_r <= pin_r + 10'h001;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) bo_r <= '0;
    else if (!bo_on) bo_r <= '0;
    else if (bo_r != 10'h3ff) bo_r <= bo_r + 10'h001;
  end

  // ==========================================================================
  // Assertions
  a_reset_exit_state: assert property ($fell(rst) |-> core_reset && !watchdog_irq)
    else $error("core not held or irq raised at reset exit");
  a_por_port_reset: assert property (analog.poweron_low |-> port_reset)
    else $error("port reset missing under power-on");
  a_pin_port_reset: assert property (pin_on |-> port_reset)
    else $error("port reset missing under pin low");
  a_por_core_reset: assert property (analog.poweron_low |=> core_reset)
    else $error("core reset missing under power-on");
  a_pin_long_reset: assert property (pin_r >= 10'(RWC_EXT_MIN_CYC + 8) |-> core_reset)
    else $error("long pin pulse gave no reset");
  a_brown_long_reset: assert property (bo_r >= 10'(RWC_BROWN_MIN_CYC + 8) |-> core_reset)
    else $error("long brown-out gave no reset");
  a_stretch_min_len: assert property ($fell(core_reset) |-> quiet_r >= 16'(STARTUP_CYCLES))
    else $error("core released before start-up delay");
  a_ref_brown_fuse: assert property (brownout_detector_fuse |-> reference_enable)
    else $error("reference off with brown-out fuse set");
  a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside read answer cycle");
  a_always_on_irq: assert property (!watchdog_always_on_fuse_n |-> !watchdog_irq)
    else $error("watchdog irq with always-on fuse");
endmodule  // rwc_reset_watchdog_control_props

bind rwc_reset_watchdog_control rwc_reset_watchdog_control_props #(
  .STARTUP_CYCLES(STARTUP_CYCLES)
) u_props (
  .sys_clk(sys_clk), .rst(rst), .analog(analog),
  .brownout_detector_fuse(brownout_detector_fuse),
  .watchdog_always_on_fuse_n(watchdog_always_on_fuse_n),
  .reset_pin_enable_fuse(reset_pin_enable_fuse), .startup_time_fuse(startup_time_fuse),
  .clock_source_fuse(clock_source_fuse), .watchdog_restart(watchdog_restart),
  .irq_ack(irq_ack), .bus(bus), .rdata(rdata), .port_reset(port_reset),
  .core_reset(core_reset), .watchdog_irq(watchdog_irq), .reference_enable(reference_enable)
);

// ---- test/rwc_supply_model.sv ----
/*
  Supply and reset pin model: turns bench dip requests into detector levels.
  Assumes requests change just after a clock edge.
*/
`timescale 1ns/1ns
module rwc_supply_model
  import rwc_pkg::*;
(
  // Dip requests: bit 0 power-on, bit 1 brown-out, bit 2 reset pin low
  input  wire logic [2:0] src_cmd,
  // Detector levels
  output rwc_analog_s     analog
);
  // Detectors move a few ns off the clock grid, as real comparators would;
  // the released pin is pulled up, so it reads high between pulses
  assign #3 analog = '{poweron_low: src_cmd[0], brownout_low: src_cmd[1],
                       reset_pin_n: ~src_cmd[2]};
endmodule  // rwc_supply_model

// ---- test/tb_reset_watchdog_control.sv ----
/*
  Self-checking bench for the reset and watchdog controller.
  Assumes the supply model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
module tb_reset_watchdog_control
  import rwc_pkg::*;
;
  localparam int SU = 16;
  logic        sys_clk, rst, bo_fuse, wdon_n, restart, ack, rd_d;
  logic        port_reset, core_reset, watchdog_irq, reference_enable;
  logic [2:0]  src_cmd;
  logic [1:0]  m;
  logic [7:0]  rdata, lfsr;
  logic [15:0] exp_q[$];
  logic [15:0] exp_h;
  rwc_bus_s    bus;
  rwc_analog_s analog;
  int          n_fail, tests_run;

  rwc_supply_model u_supply (.src_cmd(src_cmd), .analog(analog));
  rwc_reset_watchdog_control #(.STARTUP_CYCLES(SU)) dut (
    .sys_clk(sys_clk), .rst(rst), .analog(analog), .brownout_detector_fuse(bo_fuse),
    .watchdog_always_on_fuse_n(wdon_n), .reset_pin_enable_fuse(1'b1),
    .startup_time_fuse(2'h0), .clock_source_fuse(4'h1), .watchdog_restart(restart),
    .irq_ack(ack), .bus(bus), .rdata(rdata), .port_reset(port_reset),
    .core_reset(core_reset), .watchdog_irq(watchdog_irq), .reference_enable(reference_enable)
  );

  // ==========================================================================
  // Clock and hang limit
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0) n_fail++;  // Unanswered reads count as misses
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One bus cycle; restart and ack ride along with levels taken from the current lfsr bits
  task automatic cyc(logic [7:0] a, logic [7:0] d, logic w);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
    restart <= lfsr[0];
    ack <= lfsr[1] & lfsr[2];
    @(posedge sys_clk);
    bus <= '0;
    restart <= 1'b0;
    ack <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    cyc(a, d, 1'b1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back({a, e});
    cyc(a, 8'h00, 1'b0);
  endtask
  // Hold a source for n cycles, then release it
  task automatic dip(logic [2:0] s, int n);
    @(posedge sys_clk);
    src_cmd <= s;
    repeat (n) @(posedge sys_clk);
    src_cmd <= 3'h0;
  endtask
  // Bounded wait for the core to leave reset
  task automatic wait_run();
    int n;
    n = 0;
    while (core_reset !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check("startup stretch", 8'(n >= SU + 2 && n < 400), 8'h01);
    if (n == 400) stop_test();
  endtask

  // Result watcher: read data stand in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      exp_h = exp_q.pop_front();
      check($sformatf("rdata@%h", exp_h[15:8]), rdata, exp_h[7:0]);
    end
    rd_d <= bus.rd;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    bus = '0;
    bo_fuse = 1'b0;
    wdon_n = 1'b1;
    restart = 1'b0;
    ack = 1'b0;
    src_cmd = 3'h0;
    rd_d = 1'b0;
    lfsr = 8'h2a;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_run();
    #1 check("port_reset idle", 8'(port_reset), 8'h00);
    wr(RWC_ADDR_STATUS, 8'h00);
    rd(RWC_ADDR_STATUS, 8'h00);
    rd(RWC_ADDR_WDCTL, RWC_WDCTL_RST);
    rd(8'h0c, 8'h00);
    $display("test registers done");
    // Every reference request pair, random upper bits that must not stick
    lfsr = lfsr_next(lfsr);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i) ^ lfsr[1:0];
      wr(RWC_ADDR_MISC, {lfsr[7:2], m});
      #1 check("reference_enable", 8'(reference_enable), 8'(|m));
      rd(RWC_ADDR_MISC, {5'h00, |m, m});
    end
    $display("test reference done");
    // Protected watchdog changes: refused alone, taken in window, window ends
    wr(RWC_ADDR_WDCTL, 8'h08);
    wr(RWC_ADDR_WDCTL, 8'h00);
    rd(RWC_ADDR_WDCTL, 8'h08);
    wr(RWC_ADDR_WDCTL, 8'h18);
    wr(RWC_ADDR_WDCTL, 8'h05);
    rd(RWC_ADDR_WDCTL, 8'h05);
    wr(RWC_ADDR_WDCTL, 8'h1d);
    rd(RWC_ADDR_WDCTL, 8'h1d);
    repeat (4) @(posedge sys_clk);
    rd(RWC_ADDR_WDCTL, 8'h0d);
    wr(RWC_ADDR_WDCTL, 8'h00);
    rd(RWC_ADDR_WDCTL, 8'h0d);
    $display("test change sequence done");
    // Long pin pulse: flag, stretch, misc register back to initial value
    dip(3'h4, 5);
    #1 check("port_reset short pin", 8'(port_reset), 8'h01);
    dip(3'h4, 400);
    #1 check("core_reset pin", 8'(core_reset), 8'h01);
    wait_run();
    rd(RWC_ADDR_STATUS, 8'h02);
    rd(RWC_ADDR_MISC, RWC_MISC_RST);
    dip(3'h1, 20);
    wait_run();
    rd(RWC_ADDR_STATUS, 8'h01);
    $display("test pin and power-on done");
    // Second reset with brown-out detector and always-on watchdog fuses
    @(posedge sys_clk);
    rst <= 1'b1;
    bo_fuse <= 1'b1;
    wdon_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_run();
    #1 check("reference_enable fuse", 8'(reference_enable), 8'h01);
    wr(RWC_ADDR_WDCTL, 8'h40);
    rd(RWC_ADDR_WDCTL, 8'h08);
    wr(RWC_ADDR_STATUS, 8'h00);
    dip(3'h2, 100);
    repeat (10) @(posedge sys_clk);
    #1 check("core_reset short dip", 8'(core_reset), 8'h00);
    dip(3'h2, 300);
    #1 check("core_reset brown-out", 8'(core_reset), 8'h01);
    wait_run();
    rd(RWC_ADDR_STATUS, 8'h04);
    $display("test brown-out done");
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
endmodule  // tb_reset_watchdog_control
